// ---- logic/stamp_pkg.sv ----
package stamp_pkg;
  // apb byte addresses; the command word keeps its documented location
  localparam logic [15:0] ADDR_SETUP_CMD = 16'hb798;
  localparam logic [15:0] ADDR_AVAIL = 16'hb7a0;
  localparam logic [15:0] ADDR_DATA = 16'hb7a4;
  localparam logic [15:0] ADDR_STATUS = 16'hb7a8;
  // command word fields
  localparam logic [31:0] MODE_FIELD_MASK = 32'h0000_ffff;
  localparam logic [31:0] FEATURE_FIELD_MASK = 32'h000f_0000;
  localparam logic [31:0] FIRST_SLOW_SAMPLE_STAMP = 32'h0001_0000;
  localparam logic [31:0] NO_EXTRA_STAMP = 32'h0000_0000;
  localparam logic [31:0] SETUP_CMD_RESET = 32'h0000_0000;
  // status word bit positions
  localparam int STATUS_OVERRUN_BIT = 0;
  localparam int STATUS_ARMED_BIT = 1;
  localparam int STATUS_COUNT_LSB = 8;
  localparam int BYTES_PER_WORD = 4;
endpackage

// ---- logic/segment_timestamp_capture.sv ----
// Implementation choice: the APB slave port.
`timescale 1ns/1ps
// Summary of operation
// - while a timestamp mode is enabled every trigger event stores exactly one stamp if the buffer has room and card start is low in that cycle.
// - the stamp is the counter value at the trigger instant, not at the segment start.
// - slow-area samples are tied to card start, which clears the counter and arms the extra stamp.
// - a read/write command register holds both the mode and the feature selection.
// - feature bits live only under the feature field mask, apart from the mode bits.
// - with the first-slow-sample feature set, one extra stamp is stored for the first slow sample after start.
// - with the feature field zero no extra stamp is made, so stamps equal trigger events.
// - the feature works with any mode and is written together with the mode in one word.
// - the counter advances on the fast segment timebase, so the extra stamp is in those units.
// - an overrun of the stamp buffer stops all stamp transfer at once.
// - each read of the available-length register outside overrun sets the drain count to all held stamps, which is zero words when none are held.
module segment_timestamp_capture import stamp_pkg::*; #(
  parameter int DEPTH = 16,
  parameter int TS_W = 32
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // acquisition events, same clock domain
  input wire logic card_start,
  input wire logic trigger_event,
  input wire logic first_slow_sample,
  // status
  output logic stamp_overrun
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][31:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic [AW:0] drain;
    logic [31:0] cmd;
    logic [TS_W-1:0] ts;
    logic armed;
    logic late_pend;
    logic [31:0] late_val;
    logic ovr;
    logic rdy;
    logic err;
    logic take;
    logic [31:0] rdata;
  } state_t;

  state_t s_r;
  state_t s_nxt;

  logic access;
  logic done;
  logic mapped;
  logic rec_en;
  logic feat_first;
  logic pop;
  logic push;
  logic [31:0] push_val;
  logic [31:0] stamp_now;

  assign access = psel && penable;
  assign done = access && s_r.rdy;
  assign mapped = (paddr == ADDR_SETUP_CMD) || (paddr == ADDR_AVAIL) || (paddr == ADDR_DATA) ||
                  (paddr == ADDR_STATUS);
  assign rec_en = (s_r.cmd & MODE_FIELD_MASK) != 32'h0000_0000;
  assign feat_first = (s_r.cmd & FIRST_SLOW_SAMPLE_STAMP) != NO_EXTRA_STAMP;
  assign stamp_now = 32'(s_r.ts);

  // one push per cycle; a trigger wins and a colliding slow-sample stamp waits for the next cycle without a trigger
  // with its value already captured, so its time is not shifted
  always_comb begin
    push = 1'b0;
    push_val = stamp_now;
    if (!s_r.ovr && rec_en) begin
      if (trigger_event) begin
        push = 1'b1;
      end else if (s_r.late_pend) begin
        push = 1'b1;
        push_val = s_r.late_val;
      end else if (first_slow_sample && s_r.armed && feat_first) begin
        push = 1'b1;
      end
    end
  end

  // data word read pops only the stamp it actually returned, so a push landing between
  // the data capture and completion is not lost; blocked after overrun
  assign pop = done && s_r.take && (s_r.cnt != '0) && !s_r.ovr;

  always_comb begin
    s_nxt = s_r;
    s_nxt.ts = s_r.ts + TS_W'(1);
    s_nxt.rdy = 1'b0;
    s_nxt.err = 1'b0;
    s_nxt.take = 1'b0;
    // slow-sample stamp: captured on its own edge, stored now or parked
    if (first_slow_sample && s_r.armed) begin
      s_nxt.armed = 1'b0; // only the first one after start
      if (!s_r.ovr && rec_en && feat_first && trigger_event) begin
        s_nxt.late_pend = 1'b1;
        s_nxt.late_val = stamp_now;
      end
    end
    if (push && !trigger_event && s_r.late_pend) begin
      s_nxt.late_pend = 1'b0;
    end
    // buffer: overrun when full and nothing leaves
    if (push) begin
      if (s_r.cnt == (AW+1)'(DEPTH) && !pop) begin
        s_nxt.ovr = 1'b1;
      end else begin
        s_nxt.mem[s_r.wp] = push_val;
        s_nxt.wp = s_r.wp + AW'(1);
      end
    end
    if (pop) begin
      s_nxt.rp = s_r.rp + AW'(1);
      if (s_r.drain != '0) begin
        s_nxt.drain = s_r.drain - (AW+1)'(1);
      end
    end
    s_nxt.cnt = s_r.cnt + (AW+1)'(push && !s_nxt.ovr) - (AW+1)'(pop);
    // apb: answer one cycle into the access phase
    if (access && !s_r.rdy) begin
      s_nxt.rdy = 1'b1;
      s_nxt.err = !mapped;
      s_nxt.take = !pwrite && (paddr == ADDR_DATA) && (s_r.cnt != '0) && !s_r.ovr;
      unique case (paddr)
        ADDR_SETUP_CMD: s_nxt.rdata = s_r.cmd;
        ADDR_AVAIL: s_nxt.rdata = s_r.ovr ? 32'h0000_0000 : 32'(s_r.cnt) * BYTES_PER_WORD;
        ADDR_DATA: s_nxt.rdata = (s_r.cnt != '0 && !s_r.ovr) ? s_r.mem[s_r.rp] : 32'h0000_0000;
        ADDR_STATUS: begin
          s_nxt.rdata = 32'h0000_0000;
          s_nxt.rdata[STATUS_OVERRUN_BIT] = s_r.ovr;
          s_nxt.rdata[STATUS_ARMED_BIT] = s_r.armed;
          s_nxt.rdata[STATUS_COUNT_LSB +: AW+1] = s_r.cnt;
        end
        default: s_nxt.rdata = 32'h0000_0000;
      endcase
    end
    if (done && pwrite && paddr == ADDR_SETUP_CMD) begin
      s_nxt.cmd = pwdata & (MODE_FIELD_MASK | FEATURE_FIELD_MASK);
    end
    // reading the available length outside overrun hands all held words to software
    if (done && !pwrite && paddr == ADDR_AVAIL && !s_r.ovr) begin
      s_nxt.drain = s_r.cnt;
    end
    // card start restarts the timebase and arms the slow-sample stamp
    if (card_start) begin
      s_nxt.ts = '0;
      s_nxt.armed = 1'b1;
      s_nxt.late_pend = 1'b0;
      s_nxt.ovr = 1'b0;
      s_nxt.wp = '0;
      s_nxt.rp = '0;
      s_nxt.cnt = '0;
      s_nxt.drain = '0;
    end
  end

  // single state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
      s_r.cmd <= SETUP_CMD_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prdata = s_r.rdata;
  assign pready = s_r.rdy;
  assign pslverr = s_r.err;
  assign stamp_overrun = s_r.ovr;

  // checks
  property p_trig_stored;
    @(posedge pclk) disable iff (!presetn)
      (trigger_event && rec_en && !s_r.ovr && !card_start && s_r.cnt < (AW+1)'(DEPTH) && !pop)
        |=> (s_r.cnt == $past(s_r.cnt) + (AW+1)'(1));
  endproperty
  a_trig_stored: assert property (p_trig_stored) else $error("trigger did not store a stamp");

  property p_trig_value;
    @(posedge pclk) disable iff (!presetn)
      (trigger_event && rec_en && !s_r.ovr && !card_start && s_r.cnt < (AW+1)'(DEPTH))
        |=> (s_r.mem[$past(s_r.wp)] == $past(stamp_now));
  endproperty
  a_trig_value: assert property (p_trig_value) else $error("stamp is not the trigger time");

  property p_start_clears;
    @(posedge pclk) disable iff (!presetn)
      card_start |=> (s_r.ts == '0 && s_r.armed && s_r.cnt == '0);
  endproperty
  a_start_clears: assert property (p_start_clears) else $error("card start did not restart");

  property p_cmd_write;
    @(posedge pclk) disable iff (!presetn)
      (done && pwrite && paddr == ADDR_SETUP_CMD) |=> (s_r.cmd == ($past(pwdata) & 32'h000f_ffff));
  endproperty
  a_cmd_write: assert property (p_cmd_write) else $error("command word not stored");

  property p_no_extra;
    @(posedge pclk) disable iff (!presetn)
      (!feat_first && !trigger_event && !s_r.late_pend && !pop && !card_start) |=> $stable(s_r.cnt);
  endproperty
  a_no_extra: assert property (p_no_extra) else $error("stamp stored without a trigger");

  property p_first_once;
    @(posedge pclk) disable iff (!presetn)
      (first_slow_sample && s_r.armed && !card_start) |=> !s_r.armed;
  endproperty
  a_first_once: assert property (p_first_once) else $error("slow-sample stamp not disarmed");

  property p_ts_count;
    @(posedge pclk) disable iff (!presetn)
      !card_start |=> (s_r.ts == $past(s_r.ts) + TS_W'(1));
  endproperty
  a_ts_count: assert property (p_ts_count) else $error("counter missed a timebase edge");

  property p_overrun_stops;
    @(posedge pclk) disable iff (!presetn)
      (s_r.ovr && !card_start) |=> (s_r.ovr && $stable(s_r.cnt) && $stable(s_r.wp));
  endproperty
  a_overrun_stops: assert property (p_overrun_stops) else $error("transfer ran on after overrun");

  property p_avail_answer;
    @(posedge pclk) disable iff (!presetn)
      (access && !s_r.rdy && !pwrite && paddr == ADDR_AVAIL && !s_r.ovr)
        |=> (pready && prdata == 32'($past(s_r.cnt)) * 4);
  endproperty
  a_avail_answer: assert property (p_avail_answer) else $error("available length wrong");

  c_trigger: cover property (@(posedge pclk) disable iff (!presetn) push && trigger_event);
  c_first_slow: cover property (@(posedge pclk) disable iff (!presetn) push && !trigger_event && feat_first);
  c_collide: cover property (@(posedge pclk) disable iff (!presetn) s_r.late_pend);
  c_overrun: cover property (@(posedge pclk) disable iff (!presetn) $rose(s_r.ovr));
endmodule // segment_timestamp_capture

// ---- verification/acq_event_source.sv ----
`timescale 1ns/1ps
// stands in for the trigger and acquisition logic feeding the stamp block
module acq_event_source (
  // clock
  input wire logic pclk,
  // one-cycle event pulses, same clock domain
  output logic card_start,
  output logic trigger_event,
  output logic first_slow_sample
);
  initial {card_start, trigger_event, first_slow_sample} = 3'b000;
  // one pattern per cycle, changed just after the edge; a burst must end with zeros
  task automatic drive(input logic [2:0] w);
    @(posedge pclk);
    {card_start, trigger_event, first_slow_sample} <= w;
  endtask
endmodule // acq_event_source

// ---- verification/segment_timestamp_capture_tb_top.sv ----
`timescale 1ns/1ps
module segment_timestamp_capture_tb_top import stamp_pkg::*; ;
  localparam int DEPTH = 16;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e, armed, feat;
  logic card_start, trigger_event, first_slow_sample, stamp_overrun;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, r, cmd, ts, seed, v;
  logic [31:0] q[$];
  int num_errors = 0, num_checks = 0, n, m;

  segment_timestamp_capture #(.DEPTH(DEPTH), .TS_W(32)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .card_start(card_start), .trigger_event(trigger_event),
    .first_slow_sample(first_slow_sample), .stamp_overrun(stamp_overrun));
  acq_event_source src (.pclk(pclk), .card_start(card_start), .trigger_event(trigger_event),
    .first_slow_sample(first_slow_sample));

  // 25 MHz clock
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // reference stamps; reads the pre-edge event values, like the block does
  always @(posedge pclk) begin
    if (card_start) begin
      q.delete();
      armed = 1'b1;
      ts = 32'h0000_0000;
    end else begin
      if (trigger_event && cmd[15:0] != 16'h0000) q.push_back(ts);
      if (first_slow_sample && armed && cmd[16]) q.push_back(ts);
      if (first_slow_sample) armed = 1'b0;
      ts = ts + 32'h0000_0001;
    end
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    num_checks++;
    if (s !== x) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, x, s);
    end
  endtask

  // one apb transfer; waits on pready, so no slave latency is assumed
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      t++;
    end while (pready !== 1'b1 && t < 20);
    if (t >= 20) num_errors++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic finish_test();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // a hang ends the run with a failure
  initial begin
    repeat (5000) @(posedge pclk);
    num_errors++;
    finish_test();
  end

  // tests: 0 extra stamp on, 1 none, 2 overrun, 3 recording off, 4 slow sample on a trigger edge
  initial begin
    {psel, penable, pwrite, paddr, pwdata, cmd, ts, armed} = '0;
    seed = 32'h0000_8543;
    presetn = 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ADDR_SETUP_CMD, 32'h0000_0000);
    chk("cmd_reset", r, SETUP_CMD_RESET);
    for (int k = 0; k < 5; k++) begin
      feat = (k == 0) || (k == 4);
      cmd = (k == 3) ? (xs() & 32'hfff0_0000) : ((xs() & 32'hfff0_ffff) | 32'h0000_0001
        | (feat ? FIRST_SLOW_SAMPLE_STAMP : NO_EXTRA_STAMP));
      apb(1'b1, ADDR_SETUP_CMD, cmd);
      apb(1'b0, ADDR_SETUP_CMD, 32'h0000_0000);
      chk("setup_cmd", r, cmd & (MODE_FIELD_MASK | FEATURE_FIELD_MASK));
      src.drive(3'b100);
      src.drive(3'b000);
      src.drive((k == 4) ? 3'b011 : 3'b001);
      src.drive(3'b000);
      src.drive(3'b000);
      // back-to-back triggers mixed with random gaps; later slow samples must be ignored
      // at most 7 rounds keep 14 triggers plus 2 extras inside the buffer; test 2 overfills
      m = (k == 2) ? DEPTH + 1 : 1 + int'(xs() % 7);
      n = 0;
      for (int i = 0; i < m; i++) begin
        v = xs();
        src.drive({1'b0, 1'b1, v[1]});
        n++;
        if (v[0]) begin
          src.drive({1'b0, v[3], v[2]});
          n += int'(v[3]);
        end
      end
      src.drive(3'b000);
      apb(1'b0, ADDR_AVAIL, xs());
      chk("avail", r, (k == 2 || k == 3) ? 32'h0000_0000
        : 32'((n + int'(feat) + int'(k == 4)) * BYTES_PER_WORD));
      chk("overrun", {31'h0000_0000, stamp_overrun}, {31'h0000_0000, k == 2});
      while (q.size() > 0 && k != 2) begin
        apb(1'b0, ADDR_DATA, xs());
        chk("stamp", r, q.pop_front());
      end
      apb(1'b0, ADDR_DATA, 32'h0000_0000);
      chk("data_after", r, 32'h0000_0000);
      apb(1'b0, ADDR_AVAIL, 32'h0000_0000);
      chk("avail_drained", r, 32'h0000_0000);
      $display("test %0d done", k);
    end
    // unmapped word is refused in either direction and leaves the command word alone
    v = xs();
    apb(v[0], 16'hc000 | (v[15:0] & 16'h0ffc), xs());
    chk("slverr", {31'h0000_0000, e}, 32'h0000_0001);
    chk("slverr_data", r, 32'h0000_0000);
    apb(1'b0, ADDR_SETUP_CMD, xs());
    chk("cmd_kept", r, cmd & (MODE_FIELD_MASK | FEATURE_FIELD_MASK));
    finish_test();
  end
endmodule // segment_timestamp_capture_tb_top
